// ==== pkg/ide_pin_map.vh ====
`ifndef IDE_PIN_MAP_VH
`define IDE_PIN_MAP_VH

// Address width of the host I/O decode
`define IO_AW 10

// Command block, eight ports, primary and secondary
`define CMD_BASE_PRI 10'h1F0
`define CMD_BASE_SEC 10'h170
`define CMD_MASK 10'h3F8

// Control block, two ports, primary and secondary
`define CTRL_BASE_PRI 10'h3F6
`define CTRL_BASE_SEC 10'h376
`define CTRL_MASK 10'h3FE

// Extra port answered by the single data-bus enable
`define BUS_EXTRA_PORT 10'h2F7

// Strap vector positions
`define STRAP_W 4
`define STRAP_RANGE 0
`define STRAP_IFEN 1
`define STRAP_GP 2
`define STRAP_SER 3

// Strap levels assumed before capture: range pulled up, enable pulled down,
// gp select low, serial port as UART
`define STRAP_RST 4'h9

`endif

// ==== logic/addr_match.v ====
`timescale 1ns/1ps
`include "ide_pin_map.vh"

// Combinational decode of the host I/O address into the drive port blocks
module addr_match (
    // Host address and range choice
    input wire [`IO_AW-1:0] addr,
    input wire secondary,
    // Decode results
    output wire cmd_hit,
    output wire ctrl_hit,
    output wire bus_hit
);

    // Masked compare against a block base
    function blk_hit;
        input [`IO_AW-1:0] a;
        input [`IO_AW-1:0] base;
        input [`IO_AW-1:0] mask;
        begin
            blk_hit = ((a & mask) == base);
        end
    endfunction

    assign cmd_hit = blk_hit(addr, secondary ? `CMD_BASE_SEC : `CMD_BASE_PRI,
        `CMD_MASK); // see [R1]
    assign ctrl_hit = blk_hit(addr, secondary ? `CTRL_BASE_SEC : `CTRL_BASE_PRI,
        `CTRL_MASK); // see [R2]
    // Single enable answers the primary command block and the extra port only
    assign bus_hit = blk_hit(addr, `CMD_BASE_PRI, `CMD_MASK)
        | (addr == `BUS_EXTRA_PORT); // see [R7]

endmodule // addr_match

// ==== logic/strap_latch.v ====
`timescale 1ns/1ps

// Catches strap levels on the first enabled edge after reset release
module strap_latch #(
    parameter W = 4,
    parameter [W-1:0] RST_VAL = 0
) (
    // Clock and reset
    input wire mclk,
    input wire arst_n,
    input wire clk_en,
    // Strap pins and held copy
    input wire [W-1:0] strap_in,
    output reg [W-1:0] strap_reg,
    output reg done_reg
);

    // Capture once; reset takes only constants, pins are read after release
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            strap_reg <= RST_VAL;
            done_reg <= 1'b0;
        end else if (clk_en && !done_reg) begin
            strap_reg <= strap_in; // see [R17]
            done_reg <= 1'b1;
        end
    end

endmodule // strap_latch

// ==== logic/ide_pin_logic.v ====
// Function
// [R1] Command select asserts for 1F0H-1F7H, or 170H-177H when strapped secondary.
// [R2] Control select asserts for 3F6H-3F7H, or 376H-377H when strapped secondary.
// [R3] Range strap sampled at reset: high primary, low secondary; pulled up.
// [R4] Interface strap sampled at reset: high disables, low enables; pulled down.
// [R5] Low-byte buffer enable active for command or control block accesses.
// [R6] High-byte buffer enable only for command block with sixteen-bit indication.
// [R7] Single bus enable goes low for accesses to 1F0H-1F7H or 2F7H.
// [R8] Gp strap high: single enable plus two gp pins; config bit 2 overrides.
// [R9] Serial strap sampled at reset: high ordinary UART, low infrared.
// [R10] Infrared config reuses reset, control select, command select pins for infrared.
// [R11] Drive reset output low to initialize the drive, high otherwise.
// [R12] Step direction high means outward, low means inward.
// [R13] Head select high means side 0, low means side 1.
// [R14] Reduced write current low for 250Kbps, high for 500Kbps.
// [R15] Three-mode enable replaces the rate encoding with the three-mode level.
// [R16] Write data goes out active low to the selected floppy drive.
// [R17] Strap levels latched once at reset release, held until next reset.
`timescale 1ns/1ps
`include "ide_pin_map.vh"

module ide_pin_logic (
    // Clock, reset, enable
    input wire mclk,
    input wire arst_n,
    input wire clk_en,
    // Host I/O bus
    input wire [`IO_AW-1:0] io_addr,
    input wire io_strobe,
    input wire io_write,
    input wire host_d7_in,
    output reg host_d7_out,
    // Drive handshake
    input wire sixteen_bit_xfer_ind_n,
    input wire drive_reset_req,
    // Configuration bits
    input wire gp_cfg_override,
    input wire gp_cfg_bit2,
    input wire ir_rst_as_rx,
    input wire ir_cs1_as_tx,
    input wire ir_cs0_as_rx,
    input wire infrared_tx_third,
    // Gp pin controls from the core
    input wire [1:0] gp_out_data,
    input wire [1:0] gp_out_en,
    output reg [1:0] gp_in_data,
    // Strap status
    output reg drive_range_secondary,
    output reg drive_if_enabled,
    output reg serial_is_uart,
    output reg gp_mode,
    output reg straps_valid,
    // Infrared receive to the serial port
    output reg infrared_rx_third,
    output reg infrared_rx_fourth,
    // Pin 1: drive reset or infrared receive
    input wire hard_drive_reset_n_in,
    output reg hard_drive_reset_n_out,
    output reg hard_drive_reset_n_oe,
    // Pin 94: command select, interface strap, infrared receive
    input wire cmd_block_select_in,
    output reg cmd_block_select_n_out,
    output reg cmd_block_select_n_oe,
    // Pin 95: control select, range strap, infrared transmit
    input wire ctrl_block_select_in,
    output reg ctrl_block_select_n_out,
    output reg ctrl_block_select_n_oe,
    // Pin 91: low-byte enable or single enable, gp strap
    input wire low_byte_buf_en_in,
    output reg low_byte_buf_en_n_out,
    output reg low_byte_buf_en_n_oe,
    // Pin 92: high-byte enable or gp pin zero, serial strap
    input wire high_byte_buf_en_in,
    output reg high_byte_buf_en_n_out,
    output reg high_byte_buf_en_n_oe,
    // Pin 96: drive data bit 7 or gp pin one
    input wire drive_data_bit7_in,
    output reg drive_data_bit7_out,
    output reg drive_data_bit7_oe,
    // Floppy controls from the core
    input wire fdc_dir_out,
    input wire fdc_side1,
    input wire fdc_rate_500k,
    input wire three_mode_enable,
    input wire three_mode_rwc,
    input wire fdc_write_gate,
    input wire fdc_wdata,
    // Floppy open-drain pins
    output reg step_dir_out,
    output reg step_dir_oe,
    output reg head_select_out,
    output reg head_select_oe,
    output reg reduced_write_current_out,
    output reg reduced_write_current_oe,
    output reg write_enable_out,
    output reg write_enable_oe,
    output reg floppy_write_data_out,
    output reg floppy_write_data_oe
);

    wire [`STRAP_W-1:0] strap_pins;
    wire [`STRAP_W-1:0] strap_reg;
    wire strap_done;
    wire cmd_hit;
    wire ctrl_hit;
    wire bus_hit;
    reg gp_sel;
    reg cmd_sel;
    reg ctrl_sel;
    reg lo_en;
    reg hi_en;
    reg single_en;
    reg rwc_level;

    // Strap pins are read while every shared pin is released
    assign strap_pins[`STRAP_RANGE] = ctrl_block_select_in; // see [R3]
    assign strap_pins[`STRAP_IFEN] = cmd_block_select_in; // see [R4]
    assign strap_pins[`STRAP_GP] = low_byte_buf_en_in; // see [R8]
    assign strap_pins[`STRAP_SER] = high_byte_buf_en_in; // see [R9]

    strap_latch #(
        .W(`STRAP_W),
        .RST_VAL(`STRAP_RST)
    ) u_straps (
        .mclk(mclk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .strap_in(strap_pins),
        .strap_reg(strap_reg),
        .done_reg(strap_done)
    );

    addr_match u_match (
        .addr(io_addr),
        .secondary(~strap_reg[`STRAP_RANGE]), // see [R3]
        .cmd_hit(cmd_hit),
        .ctrl_hit(ctrl_hit),
        .bus_hit(bus_hit)
    );

    // Decode terms; nothing is selected while the interface is strapped off
    always @* begin
        gp_sel = gp_cfg_override ? gp_cfg_bit2 : strap_reg[`STRAP_GP]; // see [R8]
        cmd_sel = io_strobe & cmd_hit & ~strap_reg[`STRAP_IFEN]; // see [R1] [R4]
        ctrl_sel = io_strobe & ctrl_hit & ~strap_reg[`STRAP_IFEN]; // see [R2] [R4]
        lo_en = cmd_sel | ctrl_sel; // see [R5]
        hi_en = cmd_sel & ~sixteen_bit_xfer_ind_n; // see [R6]
        single_en = io_strobe & bus_hit & ~strap_reg[`STRAP_IFEN]; // see [R7]
        rwc_level = three_mode_enable ? three_mode_rwc : fdc_rate_500k; // see [R14] [R15]
    end

    // Status and infrared receive paths
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            drive_range_secondary <= 1'b0;
            drive_if_enabled <= 1'b0;
            serial_is_uart <= 1'b1;
            gp_mode <= 1'b0;
            straps_valid <= 1'b0;
            infrared_rx_third <= 1'b1;
            infrared_rx_fourth <= 1'b1;
            gp_in_data <= 2'h0;
            host_d7_out <= 1'b0;
        end else if (clk_en) begin
            drive_range_secondary <= ~strap_reg[`STRAP_RANGE];
            drive_if_enabled <= ~strap_reg[`STRAP_IFEN];
            serial_is_uart <= strap_reg[`STRAP_SER]; // see [R9]
            gp_mode <= gp_sel;
            straps_valid <= strap_done;
            // Idle high when the pin is not lent to the infrared port
            infrared_rx_third <= ir_rst_as_rx ? hard_drive_reset_n_in : 1'b1; // see [R10]
            infrared_rx_fourth <= ir_cs0_as_rx ? cmd_block_select_in : 1'b1; // see [R10]
            gp_in_data <= gp_sel ? {drive_data_bit7_in, high_byte_buf_en_in} : 2'h0;
            host_d7_out <= drive_data_bit7_in;
        end
    end

    // Drive-side pins. Output enables stay low until the straps are caught,
    // so the external pulls set the strap levels undisturbed.
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            hard_drive_reset_n_out <= 1'b1;
            hard_drive_reset_n_oe <= 1'b0;
            cmd_block_select_n_out <= 1'b1;
            cmd_block_select_n_oe <= 1'b0;
            ctrl_block_select_n_out <= 1'b1;
            ctrl_block_select_n_oe <= 1'b0;
            low_byte_buf_en_n_out <= 1'b1;
            low_byte_buf_en_n_oe <= 1'b0;
            high_byte_buf_en_n_out <= 1'b1;
            high_byte_buf_en_n_oe <= 1'b0;
            drive_data_bit7_out <= 1'b0;
            drive_data_bit7_oe <= 1'b0;
        end else if (clk_en) begin
            // Reset pin, or infrared receive input
            hard_drive_reset_n_out <= ~drive_reset_req; // see [R11]
            hard_drive_reset_n_oe <= strap_done & ~ir_rst_as_rx; // see [R10]
            // Command select, or infrared receive input
            cmd_block_select_n_out <= ~cmd_sel; // see [R1]
            cmd_block_select_n_oe <= strap_done & ~ir_cs0_as_rx; // see [R10]
            // Control select, or infrared transmit output
            ctrl_block_select_n_out <= ir_cs1_as_tx ? infrared_tx_third : ~ctrl_sel; // see [R2] [R10]
            ctrl_block_select_n_oe <= strap_done;
            // Low-byte enable or single bus enable, both active low
            low_byte_buf_en_n_out <= gp_sel ? ~single_en : ~lo_en; // see [R5] [R7] [R8]
            low_byte_buf_en_n_oe <= strap_done;
            // High-byte enable, or gp pin zero under core control
            if (gp_sel) begin
                high_byte_buf_en_n_out <= gp_out_data[0]; // see [R8]
                high_byte_buf_en_n_oe <= strap_done & gp_out_en[0];
            end else begin
                high_byte_buf_en_n_out <= ~hi_en; // see [R6]
                high_byte_buf_en_n_oe <= strap_done;
            end
            // Data bit 7 follows host writes to the command block, or gp pin one
            if (gp_sel) begin
                drive_data_bit7_out <= gp_out_data[1]; // see [R8]
                drive_data_bit7_oe <= strap_done & gp_out_en[1];
            end else begin
                drive_data_bit7_out <= host_d7_in;
                drive_data_bit7_oe <= strap_done & cmd_sel & io_write;
            end
        end
    end

    // Floppy open-drain pins: the enable pulls low, a high level floats
    // up through the drive's terminator
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            step_dir_out <= 1'b0;
            step_dir_oe <= 1'b0;
            head_select_out <= 1'b0;
            head_select_oe <= 1'b0;
            reduced_write_current_out <= 1'b0;
            reduced_write_current_oe <= 1'b0;
            write_enable_out <= 1'b0;
            write_enable_oe <= 1'b0;
            floppy_write_data_out <= 1'b0;
            floppy_write_data_oe <= 1'b0;
        end else if (clk_en) begin
            step_dir_oe <= ~fdc_dir_out; // see [R12]
            head_select_oe <= fdc_side1; // see [R13]
            reduced_write_current_oe <= ~rwc_level; // see [R14] [R15]
            write_enable_oe <= fdc_write_gate;
            // Data only pulses while the write gate is open
            floppy_write_data_oe <= fdc_write_gate & fdc_wdata; // see [R16]
        end
    end

endmodule // ide_pin_logic

// ==== dv/ide_pin_logic_chk.sv ====
`timescale 1ns/1ps
`include "ide_pin_map.vh"

// Watches decode, floppy pins and strap status at the pin logic ports
module ide_pin_logic_chk (
    // Clock and reset
    input wire mclk,
    input wire arst_n,
    input wire clk_en,
    // Host side, configuration and strap status
    input wire [`IO_AW-1:0] io_addr,
    input wire io_strobe, sixteen_bit_xfer_ind_n, drive_reset_req, ir_rst_as_rx,
    input wire straps_valid, drive_range_secondary, drive_if_enabled, gp_mode,
    // Drive pins
    input wire cmd_block_select_n_out, ctrl_block_select_n_out,
    input wire low_byte_buf_en_n_out, high_byte_buf_en_n_out, hard_drive_reset_n_out,
    // Floppy controls and pins
    input wire fdc_dir_out, fdc_side1, fdc_rate_500k, three_mode_enable, three_mode_rwc,
    input wire fdc_write_gate, fdc_wdata, step_dir_oe, head_select_oe,
    input wire reduced_write_current_oe, floppy_write_data_oe
);
    wire cmd_hit;
    wire ctrl_hit;
    wire go;
    wire one_bus;

    // Decode is rebuilt here so a wrong base or mask in the design shows up
    assign cmd_hit = (io_addr & `CMD_MASK) ==
        (drive_range_secondary ? `CMD_BASE_SEC : `CMD_BASE_PRI);
    assign ctrl_hit = (io_addr & `CTRL_MASK) ==
        (drive_range_secondary ? `CTRL_BASE_SEC : `CTRL_BASE_PRI);
    assign go = io_strobe && straps_valid && drive_if_enabled;
    // Single enable decode ignores the range strap
    assign one_bus = ((io_addr & `CMD_MASK) == `CMD_BASE_PRI) || (io_addr == `BUS_EXTRA_PORT);

    default clocking @(posedge mclk); endclocking
    // Frozen cycles hold the pins, so no one-cycle claim is made across them
    default disable iff (!arst_n || !clk_en);

    AST_CMD_SEL: assert property (go && cmd_hit |=> !cmd_block_select_n_out)
        else $error("command select missing");
    AST_CTRL_SEL: assert property (go && ctrl_hit |=> !ctrl_block_select_n_out)
        else $error("control select missing");
    AST_LOW_EN: assert property (go && !gp_mode && (cmd_hit || ctrl_hit) |=> !low_byte_buf_en_n_out)
        else $error("low byte enable missing");
    AST_HIGH_EN: assert property (straps_valid && !gp_mode |=>
        high_byte_buf_en_n_out == !$past(go && cmd_hit && !sixteen_bit_xfer_ind_n))
        else $error("high byte enable wrong");
    AST_ONE_BUS: assert property (go && gp_mode && one_bus |=> !low_byte_buf_en_n_out)
        else $error("single bus enable missing");
    AST_IF_OFF: assert property (straps_valid && !drive_if_enabled |->
        cmd_block_select_n_out && low_byte_buf_en_n_out)
        else $error("select while interface disabled");
    AST_DRV_RST: assert property (straps_valid && drive_if_enabled && !ir_rst_as_rx |=>
        hard_drive_reset_n_out == !$past(drive_reset_req))
        else $error("drive reset level wrong");
    AST_DIR_HEAD: assert property (straps_valid |=>
        step_dir_oe == !$past(fdc_dir_out) && head_select_oe == $past(fdc_side1))
        else $error("direction or head pin wrong");
    AST_RWC: assert property (straps_valid |=> reduced_write_current_oe ==
        !$past(three_mode_enable ? three_mode_rwc : fdc_rate_500k))
        else $error("write current pin wrong");
    AST_WDATA: assert property (straps_valid |=>
        floppy_write_data_oe == $past(fdc_write_gate && fdc_wdata))
        else $error("write data pin wrong");
    AST_STRAP_HOLD: assert property (straps_valid ##1 straps_valid |->
        $stable(drive_range_secondary) && $stable(drive_if_enabled))
        else $error("strap status moved");

    // Main scenarios
    COV_CMD16: cover property (go && cmd_hit && !sixteen_bit_xfer_ind_n);
    COV_ONE_BUS: cover property (go && gp_mode && io_addr == `BUS_EXTRA_PORT);
    COV_THREE: cover property (straps_valid && three_mode_enable);
endmodule // ide_pin_logic_chk

bind ide_pin_logic ide_pin_logic_chk i_chk (.*);

// ==== dv/drive_side_model.sv ====
`timescale 1ns/1ps

// Drive side: strap pulls on released pins, sixteen-bit answer, noisy data line
module drive_side_model (
    // Clock and bench choices
    input wire mclk,
    input wire [3:0] strap_lvl,
    input wire xfer16,
    // Pin drivers of the pin logic
    input wire cmd_block_select_n_out, cmd_block_select_n_oe,
    input wire ctrl_block_select_n_out, ctrl_block_select_n_oe,
    input wire low_byte_buf_en_n_out, low_byte_buf_en_n_oe,
    input wire high_byte_buf_en_n_out, high_byte_buf_en_n_oe,
    input wire hard_drive_reset_n_out, hard_drive_reset_n_oe,
    input wire drive_data_bit7_out, drive_data_bit7_oe,
    // Resolved pin levels
    output wire cmd_block_select_in, ctrl_block_select_in,
    output wire low_byte_buf_en_in, high_byte_buf_en_in,
    output wire hard_drive_reset_n_in, drive_data_bit7_in,
    output wire sixteen_bit_xfer_ind_n
);
    logic noise = 1'b0;

    // A released strap pin falls to its strap resistor level; a released reset pin reads the noise source
    assign ctrl_block_select_in = ctrl_block_select_n_oe ? ctrl_block_select_n_out : strap_lvl[0];
    assign cmd_block_select_in = cmd_block_select_n_oe ? cmd_block_select_n_out : strap_lvl[1];
    assign low_byte_buf_en_in = low_byte_buf_en_n_oe ? low_byte_buf_en_n_out : strap_lvl[2];
    assign high_byte_buf_en_in = high_byte_buf_en_n_oe ? high_byte_buf_en_n_out : strap_lvl[3];
    assign hard_drive_reset_n_in = hard_drive_reset_n_oe ? hard_drive_reset_n_out : noise;
    // Unpulled data line toggles so a stale level never reads back as valid
    assign drive_data_bit7_in = drive_data_bit7_oe ? drive_data_bit7_out : noise;
    assign sixteen_bit_xfer_ind_n = ~xfer16;

    // Noise source
    always @(posedge mclk) begin
        noise <= ~noise;
    end
endmodule // drive_side_model

// ==== dv/ide_pin_logic_tb.sv ====
`timescale 1ns/1ps

module ide_pin_logic_tb;
    logic mclk, arst_n, clk_en, io_strobe, io_write, host_d7_in, host_d7_out, drive_reset_req;
    logic [9:0] io_addr, a;
    logic gp_cfg_override, gp_cfg_bit2, ir_rst_as_rx, ir_cs1_as_tx, ir_cs0_as_rx;
    logic infrared_tx_third, infrared_rx_third, infrared_rx_fourth, xfer16, s, w;
    logic [1:0] gp_out_data, gp_out_en, gp_in_data;
    logic [3:0] strap_lvl, e, st;
    logic drive_range_secondary, drive_if_enabled, serial_is_uart, gp_mode, straps_valid;
    logic sixteen_bit_xfer_ind_n, hard_drive_reset_n_in, hard_drive_reset_n_out;
    logic hard_drive_reset_n_oe, cmd_block_select_in, cmd_block_select_n_out;
    logic cmd_block_select_n_oe, ctrl_block_select_in, ctrl_block_select_n_out;
    logic ctrl_block_select_n_oe, low_byte_buf_en_in, low_byte_buf_en_n_out;
    logic low_byte_buf_en_n_oe, high_byte_buf_en_in, high_byte_buf_en_n_out;
    logic high_byte_buf_en_n_oe, drive_data_bit7_in, drive_data_bit7_out, drive_data_bit7_oe;
    logic fdc_dir_out, fdc_side1, fdc_rate_500k, three_mode_enable, three_mode_rwc;
    logic fdc_write_gate, fdc_wdata, step_dir_out, step_dir_oe, head_select_out;
    logic head_select_oe, reduced_write_current_out, reduced_write_current_oe;
    logic write_enable_out, write_enable_oe, floppy_write_data_out, floppy_write_data_oe;
    integer seed, error_cnt, cmp_count, i, k;
    logic [9:0] cor [0:9];
    logic [3:0] tbl [0:3];

    ide_pin_logic i_dut (.*);
    drive_side_model i_drv (.*);

    // Clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic chk(input string nm, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s exp %b got %b", nm, exp, got);
        end
    endtask

    // Expected active-low pins: cmd, ctrl, low enable, high enable
    function automatic logic [3:0] exp_n(input logic [9:0] a, input logic s, w,
                                         input logic [3:0] st);
        logic c, t;
        c = (a & 10'h3F8) == (st[0] ? 10'h1F0 : 10'h170);
        t = (a & 10'h3FE) == (st[0] ? 10'h3F6 : 10'h376);
        s = s & ~st[1];
        exp_n[3] = ~(s & c);
        exp_n[2] = ~(s & t);
        exp_n[1] = st[2] ? ~(s & ((a & 10'h3F8) == 10'h1F0 | a == 10'h2F7)) : ~(s & (c | t));
        exp_n[0] = ~(s & c & w);
    endfunction

    // Reset with chosen strap levels, then check the captured status
    task automatic boot(input logic [3:0] st);
        strap_lvl = st;
        arst_n <= 1'b0;
        repeat (6) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        chk("range_sec", ~st[0], drive_range_secondary);
        chk("if_enabled", ~st[1], drive_if_enabled);
        chk("gp_mode", st[2], gp_mode);
        chk("uart", st[3], serial_is_uart);
    endtask

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Watchdog, about two and a half times the expected run
    initial begin
        #200000;
        error_cnt++;
        wrap_up;
    end

    initial begin
        seed = 82134;
        error_cnt = 0;
        cmp_count = 0;
        {clk_en, arst_n, strap_lvl} = 6'h29;
        {io_addr, io_strobe, xfer16, io_write, host_d7_in, drive_reset_req} = 0;
        {gp_cfg_override, gp_cfg_bit2, ir_rst_as_rx, ir_cs1_as_tx, ir_cs0_as_rx} = 0;
        {infrared_tx_third, gp_out_data, gp_out_en, fdc_dir_out, fdc_side1} = 0;
        {fdc_rate_500k, three_mode_enable, three_mode_rwc, fdc_write_gate, fdc_wdata} = 0;
        cor = '{10'h1F0, 10'h1F7, 10'h170, 10'h177, 10'h3F6, 10'h3F7, 10'h376, 10'h377,
                10'h2F7, 10'h1EF};
        // Primary, secondary, gp with secondary, interface disabled with infrared
        tbl = '{4'h9, 4'h8, 4'hC, 4'h2};
        for (k = 0; k < 4; k++) begin
            st = tbl[k];
            // Pin reuse and override go back to plain use before each boot
            gp_cfg_override <= 1'b0;
            {ir_cs0_as_rx, ir_cs1_as_tx} <= 2'h0;
            boot(st);
            for (i = 0; i < 200; i++) begin
                a = i[0] ? cor[$unsigned($random(seed)) % 10] : 10'($random(seed));
                {s, w} = 2'($random(seed));
                @(posedge mclk);
                io_addr <= a;
                io_strobe <= s;
                xfer16 <= w;
                {fdc_dir_out, fdc_side1, fdc_rate_500k, three_mode_enable, three_mode_rwc,
                 fdc_write_gate, fdc_wdata, io_write, host_d7_in, infrared_tx_third,
                 gp_out_data, gp_out_en, drive_reset_req, gp_cfg_bit2} <= 16'($random(seed));
                @(posedge mclk);
                #1;
                e = exp_n(a, s, w, st);
                chk("cmd_sel", e[3], cmd_block_select_n_out);
                chk("ctrl_sel", e[2], ctrl_block_select_n_out);
                chk("low_en", e[1], low_byte_buf_en_n_out);
                if (!st[2]) chk("high_en", e[0], high_byte_buf_en_n_out);
            end
            if (k == 2) begin
                // Later pin levels leave the latched straps alone; pins lent to infrared
                @(posedge mclk);
                {io_strobe, ir_cs0_as_rx, ir_cs1_as_tx, infrared_tx_third} <= 4'h6;
                gp_cfg_override <= 1'b1;
                gp_cfg_bit2 <= 1'b0;
                strap_lvl <= 4'h0;
                repeat (3) @(posedge mclk);
                #1;
                chk("ir_rx4", 1'b0, infrared_rx_fourth);
                chk("ir_tx3", 1'b0, ctrl_block_select_n_out);
                chk("range_held", 1'b1, drive_range_secondary);
                chk("gp_override", 1'b0, gp_mode);
                // Nothing moves while the clock enable is low
                @(posedge mclk);
                {clk_en, infrared_tx_third} <= 2'h1;
                repeat (3) @(posedge mclk);
                #1;
                chk("frozen", 1'b0, ctrl_block_select_n_out);
                @(posedge mclk);
                clk_en <= 1'b1;
                repeat (2) @(posedge mclk);
                #1;
                chk("thawed", 1'b1, ctrl_block_select_n_out);
            end
        end
        wrap_up;
    end
endmodule // ide_pin_logic_tb
